// [shared/cfg_loader_defs.svh]
/*
 * Offsets, field positions, reset values and timing counts for the startup
 * configuration loader. Assumes inclusion by bare name from design files.
 */
`ifndef CFG_LOADER_DEFS_SVH
`define CFG_LOADER_DEFS_SVH

// ----------------------------------------------------------------------
// Flash location of the startup configuration byte.
// ----------------------------------------------------------------------
`define CFG_FLASH_ADDR 16'h0080
`define CFG_FLASH_AW 16

// ----------------------------------------------------------------------
// Field positions inside the configuration byte.
// ----------------------------------------------------------------------
`define CFG_SETTLE_HI_BIT 6
`define CFG_SETTLE_LO_BIT 5
`define CFG_RESET_PIN_BIT 3
`define CFG_CLK_HI_BIT 2
`define CFG_CLK_LO_BIT 1
`define CFG_SLOW_LOCK_BIT 0

// ----------------------------------------------------------------------
// Settling waits as exponents of the main clock period.
// ----------------------------------------------------------------------
`define SETTLE_EXP_0 10
`define SETTLE_EXP_1 12
`define SETTLE_EXP_2 15
`define SETTLE_EXP_3 17

// ----------------------------------------------------------------------
// Register offsets on the plain register port.
// ----------------------------------------------------------------------
`define REG_CFG_BYTE 8'h00
`define REG_UV_DETECT 8'h04
`define REG_IRQ_FLAGS0 8'h08
`define REG_SLOW_OSC_MODE 8'h0C
`define REG_EVT_STATUS 8'h10
`define REG_EVT_MASK 8'h14

// ----------------------------------------------------------------------
// Register field positions and reset values.
// ----------------------------------------------------------------------
`define UV_FLAG_BIT 0
`define UV_MODE_BIT 1
`define UV_ENABLE_BIT 7
`define UV_PEND_BIT 1
`define SLOW_HALT_BIT 0
`define UV_DETECT_RST 8'h00
`define EVT_MASK_RST 2'h0
`define EVT_LOADED_BIT 0
`define EVT_UV_BIT 1

`endif

// [shared/cfg_loader_pkg.sv]
/*
 * Types shared by the startup configuration loader files.
 * Assumes the defs header is compiled alongside.
 */
package cfg_loader_pkg;

   // Clock source choices decoded from the configuration byte.
   typedef enum logic [1:0] {
      CLK_CRYSTAL,
      CLK_EXTERNAL,
      CLK_INTERNAL
   } clk_source_t;

   // Decoded settings held until the next reset.
   typedef struct packed {
      logic [1:0] settle_sel;
      logic reset_pin_function_sel;
      clk_source_t clk_source;
      logic slow_osc_lock;
   } cfg_settings_t;

   // Pin role outputs for the shared oscillator and reset pins.
   typedef struct packed {
      logic osc_pin_a_port;
      logic osc_pin_b_port;
      logic reset_pin_as_input;
   } pin_roles_t;

endpackage

// [tb/cfg_flash_model.sv]
/*
 * Behavioural model of the on-chip flash that holds the startup configuration byte.
 * Assumes the loader raises its read strobe with the configuration address.
 * It also assumes the bench supplies the byte contents.
 */
`timescale 1ns/1ps
`include "cfg_loader_defs.svh"

module cfg_flash_model (
   // Clock.
   input wire logic core_clk_in,
   // Read port from the loader.
   input wire logic flash_rd_in,
   input wire logic [`CFG_FLASH_AW-1:0] flash_addr_in,
   // Contents of the configuration location.
   input wire logic [7:0] stored_byte_in,
   // Read data.
   output logic [7:0] flash_data_out
);
   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   // The byte stands for one cycle after a read. Any other cycle toggles the bus,
   // so a loader that samples one cycle late cannot pass by luck.
   initial flash_data_out = 8'h00;
   always @(posedge core_clk_in) begin
      if (flash_rd_in && flash_addr_in == `CFG_FLASH_ADDR) begin
         flash_data_out <= stored_byte_in;
      end else begin
         flash_data_out <= ~flash_data_out;
      end
   end
endmodule

// [tb/option_byte_config_loader_bench.sv]
/*
 * Self-checking bench for the startup configuration loader with a flash model.
 * Assumes one 125 MHz clock and a synchronous active-low reset.
 * It also assumes that the register port answers one cycle after a read.
 */
`timescale 1ns/1ps
`include "cfg_loader_defs.svh"

module option_byte_config_loader_bench;
   // ----------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------
   logic core_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic flash_rd;
   logic [`CFG_FLASH_AW-1:0] flash_addr;
   logic [7:0] flash_data;
   logic [7:0] cfg_byte = 8'h9C;
   logic reset_pin_n = 1'b1;
   logic supply_low = 1'b0;
   logic halt_mode = 1'b0;
   logic stop_mode = 1'b0;
   logic wdt_sel_slow = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [7:0] rd_val;
   logic core_reset, config_valid, slow_run, wdt_en, wdt_slow, h1_en, irq;
   cfg_loader_pkg::cfg_settings_t settings;
   cfg_loader_pkg::pin_roles_t pins;
   int fails = 0;
   int total_checks = 0;
   int cycles = 0;

   // The clock toggles every half period of 4 ns.
   always #4 core_clk_in = ~core_clk_in;

   option_byte_config_loader i_option_byte_config_loader (
      .core_clk_in(core_clk_in), .rstn_in(rstn_in), .flash_rd_out(flash_rd),
      .flash_addr_out(flash_addr), .flash_data_in(flash_data),
      .reset_pin_n_in(reset_pin_n), .supply_low_in(supply_low),
      .halt_mode_in(halt_mode), .stop_mode_in(stop_mode), .wdt_sel_slow_in(wdt_sel_slow),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .core_reset_out(core_reset),
      .config_valid_out(config_valid), .settings_out(settings), .pin_roles_out(pins),
      .slow_osc_run_out(slow_run), .wdt_clk_en_out(wdt_en),
      .wdt_force_slow_out(wdt_slow), .timer_h1_clk_en_out(h1_en), .irq_out(irq));

   cfg_flash_model i_cfg_flash_model (
      .core_clk_in(core_clk_in), .flash_rd_in(flash_rd), .flash_addr_in(flash_addr),
      .stored_byte_in(cfg_byte), .flash_data_out(flash_data));

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   // Comparison, counted and reported at once.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic check_bit(input logic seen, input logic exp);
      check({7'h00, seen}, {7'h00, exp});
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk_in);
      reg_wr <= 1'b0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe, so sample them there.
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_in);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk_in);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // Holds reset for six cycles, then counts edges until the settings apply.
   task automatic do_reset(input logic [7:0] b, input logic pin_n, output int n);
      @(posedge core_clk_in);
      cfg_byte <= b;
      reset_pin_n <= pin_n;
      rstn_in <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      n = 0;
      while (config_valid !== 1'b1 && n < (pin_n ? 40000 : 10)) begin
         @(posedge core_clk_in);
         #1;
         n++;
      end
   endtask

   function automatic logic [7:0] exp_set(input logic [7:0] b);
      return {2'h0, b[6:5], b[3], b[2] ? 2'h2 : {1'b0, b[1]}, b[0]};
   endfunction

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // Load a byte, check wait, decoded settings, pin roles and read-only holding.
   task automatic load_case(input logic [7:0] b);
      int n, e, lo;
      case (b[6:5])
         2'b00: e = `SETTLE_EXP_0;
         2'b01: e = `SETTLE_EXP_1;
         2'b10: e = `SETTLE_EXP_2;
         default: e = `SETTLE_EXP_3;
      endcase
      lo = (b[2:1] == 2'b00) ? (1 << e) : 1;
      do_reset(b, 1'b1, n);
      check_bit(n >= lo && n <= lo + 4, 1'b1);
      check({2'h0, settings}, exp_set(b));
      check({5'h00, pins}, {5'h00, b[2], b[2] | b[1], ~b[3]});
      reg_read(`REG_CFG_BYTE, rd_val);
      check(rd_val, b);
      reg_write(`REG_CFG_BYTE, ~b);
      reg_read(`REG_CFG_BYTE, rd_val);
      check(rd_val, b);
      check({2'h0, settings}, exp_set(b));
      @(posedge core_clk_in);
      reset_pin_n <= 1'b0;
      #1;
      check_bit(core_reset, b[3]);
      @(posedge core_clk_in);
      reset_pin_n <= 1'b1;
      $display("load case %h finished", b);
   endtask

   // Pin held low before the fetch holds reset and loading until it rises.
   task automatic pin_case(input logic [7:0] b);
      int n;
      do_reset(b, 1'b0, n);
      repeat (10) @(posedge core_clk_in);
      #1;
      check_bit(core_reset, 1'b1);
      check_bit(config_valid, 1'b0);
      @(posedge core_clk_in);
      reset_pin_n <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      #1;
      check_bit(core_reset, 1'b0);
      $display("pin case %h finished", b);
   endtask

   task automatic osc_case(input logic lock);
      @(posedge core_clk_in);
      wdt_sel_slow <= 1'b1;
      reg_write(`REG_SLOW_OSC_MODE, 8'h01);
      check_bit(slow_run, lock);
      check_bit(wdt_slow, lock);
      reg_write(`REG_SLOW_OSC_MODE, 8'h00);
      check_bit(slow_run, 1'b1);
      check_bit(wdt_en, 1'b1);
      @(posedge core_clk_in);
      halt_mode <= 1'b1;
      #1;
      if (!lock) check_bit(wdt_en, 1'b0);
      @(posedge core_clk_in);
      halt_mode <= 1'b0;
      stop_mode <= 1'b1;
      #1;
      check_bit(h1_en, 1'b1);
      @(posedge core_clk_in);
      stop_mode <= 1'b0;
      wdt_sel_slow <= 1'b0;
      #1;
      if (!lock) check_bit(wdt_en, 1'b0);
      $display("oscillator case %b finished", lock);
   endtask

   // Interrupt-mode detector, pending flag and sticky events with mask.
   task automatic uv_case;
      reg_write(`REG_EVT_MASK, 8'h03);
      reg_read(`REG_EVT_STATUS, rd_val);
      check(rd_val, 8'h01);
      check_bit(irq, 1'b1);
      reg_write(`REG_EVT_STATUS, 8'h01);
      reg_read(`REG_EVT_STATUS, rd_val);
      check(rd_val, 8'h00);
      check_bit(irq, 1'b0);
      reg_write(`REG_UV_DETECT, 8'h80);
      @(posedge core_clk_in);
      supply_low <= 1'b1;
      reg_read(`REG_UV_DETECT, rd_val);
      check(rd_val, 8'h81);
      reg_read(`REG_IRQ_FLAGS0, rd_val);
      check(rd_val, 8'h02);
      reg_read(`REG_EVT_STATUS, rd_val);
      check(rd_val, 8'h02);
      check_bit(irq, 1'b1);
      reg_write(`REG_IRQ_FLAGS0, 8'h02);
      reg_read(`REG_IRQ_FLAGS0, rd_val);
      check(rd_val, 8'h02);
      reg_write(`REG_IRQ_FLAGS0, 8'h00);
      reg_read(`REG_IRQ_FLAGS0, rd_val);
      check(rd_val, 8'h00);
      reg_write(`REG_EVT_STATUS, 8'h02);
      reg_write(`REG_EVT_MASK, 8'h01);
      @(posedge core_clk_in);
      supply_low <= 1'b0;
      reg_read(`REG_UV_DETECT, rd_val);
      check(rd_val, 8'h80);
      @(posedge core_clk_in);
      supply_low <= 1'b1;
      reg_read(`REG_EVT_STATUS, rd_val);
      check(rd_val, 8'h02);
      check_bit(irq, 1'b0);
      reg_write(`REG_UV_DETECT, 8'h00);
      reg_read(`REG_UV_DETECT, rd_val);
      check(rd_val, 8'h00);
      @(posedge core_clk_in);
      supply_low <= 1'b0;
      $display("undervoltage case finished");
   endtask

   // Reset-mode detector follows every supply crossing.
   task automatic lvr_case;
      int n;
      reg_write(`REG_UV_DETECT, 8'h82);
      repeat (2) begin
         @(posedge core_clk_in);
         supply_low <= 1'b1;
         repeat (2) @(posedge core_clk_in);
         #1;
         check_bit(core_reset, 1'b1);
         @(posedge core_clk_in);
         supply_low <= 1'b0;
         n = 0;
         while (core_reset !== 1'b0 && n < 50) begin
            @(posedge core_clk_in);
            #1;
            n++;
         end
         check_bit(core_reset, 1'b0);
      end
      $display("detector reset case finished");
   endtask

   // ----------------------------------------------------------------------
   // Sequence and verdict
   // ----------------------------------------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // The longest legal run is the three crystal waits plus a few hundred cycles.
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 45000) begin
         fails++;
         wrap_up();
      end
   end

   initial begin
      load_case(8'h93);
      osc_case(1'b1);
      load_case(8'h9E);
      load_case(8'hFC);
      load_case(8'h98);
      load_case(8'hB8);
      load_case(8'hD8);
      load_case(8'h9C);
      osc_case(1'b0);
      uv_case();
      lvr_case();
      pin_case(8'h9C);
      pin_case(8'h93);
      wrap_up();
   end
endmodule

// [verilog/event_irq.sv]
/*
 * Sticky event status with mask and one level interrupt output.
 * Assumes write-one-to-clear from the register port; set beats clear.
 */
`timescale 1ns/1ps

module event_irq #(
   parameter int N = 2
) (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Events and software access.
   input wire logic [N-1:0] event_in,
   input wire logic [N-1:0] clear_in,
   input wire logic [N-1:0] mask_in,
   // Status and interrupt.
   output logic [N-1:0] status_out,
   output logic irq_out
);

   // An event in the clearing cycle keeps its bit set.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         status_out <= '0;
      end else begin
         status_out <= (status_out & ~clear_in) | event_in;
      end
   end

   assign irq_out = |(status_out & mask_in);

endmodule

// [verilog/option_byte_config_loader.sv]
/*
 * Startup configuration loader: fetches the configuration byte from flash
 * after reset, holds its settings, drives clock, pin and slow oscillator
 * gating, and keeps the undervoltage flags. Assumes a flash read port that
 * returns data one cycle after the read request, and inputs synchronous to
 * core_clk_in.
 */
// Chosen here: the address-and-strobe port.
// Overview of operation
// [R01] Fetch byte 0080H after every reset release.
// [R02] Byte layout fixed by flash contents.
// [R03] Settle field picks 2^10/12/15/17 waits.
// [R04] Settle wait only for crystal source.
// [R05] Reset pin function bit selects reset/port.
// [R06] Reset pin holds reset before byte applied.
// [R07] Clock field selects crystal, external, internal.
// [R08] Oscillator pins freed per clock source.
// [R09] Lock bit overrides slow oscillator stop.
// [R10] Locked oscillator forces watchdog slow clock.
// [R11] Stoppable: watchdog gated in halt/stop.
// [R12] Timer H1 clocked in stop while running.
// [R13] Detector reset follows supply each crossing.
// [R14] Pending flag bit 1, cleared by zero.
// [R15] Detect flag readable at bit 0.
// [R16] Programmer powered before target if port.
// [R17] Flag 1 below level, else 0.
// [R18] Settings held constant until next reset.
`timescale 1ns/1ps
`include "cfg_loader_defs.svh"

module option_byte_config_loader #(
   parameter int SETTLE_W = 18
) (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Flash read port.
   output logic flash_rd_out,
   output logic [`CFG_FLASH_AW-1:0] flash_addr_out,
   input wire logic [7:0] flash_data_in,
   // Shared reset pin level, low means reset requested.
   input wire logic reset_pin_n_in,
   // Supply comparator, high while supply below detection level.
   input wire logic supply_low_in,
   // Power modes and watchdog clock choice.
   input wire logic halt_mode_in,
   input wire logic stop_mode_in,
   input wire logic wdt_sel_slow_in,
   // Register port.
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Results.
   output logic core_reset_out,
   output logic config_valid_out,
   output cfg_loader_pkg::cfg_settings_t settings_out,
   output cfg_loader_pkg::pin_roles_t pin_roles_out,
   output logic slow_osc_run_out,
   output logic wdt_clk_en_out,
   output logic wdt_force_slow_out,
   output logic timer_h1_clk_en_out,
   output logic irq_out
);

   typedef enum logic [1:0] {
      FETCH,
      CAPTURE,
      SETTLE,
      RUN
   } load_state_t;

   load_state_t state;
   logic [7:0] cfg_byte;
   logic settle_start;
   logic settle_done;
   logic slow_osc_halt_req;
   logic [7:0] undervolt_detect_reg;
   logic irq_request_flags_0;
   logic [1:0] evt_mask;
   logic [1:0] evt_status;
   logic [1:0] evt_clear;
   logic [1:0] evt_in;
   logic loaded_pulse;
   logic uv_enable;
   logic uv_reset_mode;
   logic undervolt_flag;
   logic uv_flag_prev;
   logic wr_uv;
   logic wr_pend;

   // Decode the two-bit clock field; the low bit is ignored when the high is set.
   function automatic cfg_loader_pkg::clk_source_t decode_clk(input logic [7:0] b);
      if (b[`CFG_CLK_HI_BIT]) begin
         decode_clk = cfg_loader_pkg::CLK_INTERNAL;
      end else if (b[`CFG_CLK_LO_BIT]) begin
         decode_clk = cfg_loader_pkg::CLK_EXTERNAL;
      end else begin
         decode_clk = cfg_loader_pkg::CLK_CRYSTAL;
      end
   endfunction

   // ----------------------------------------------------------------------
   // Load sequence
   // ----------------------------------------------------------------------

   // Every reset restarts the fetch; a low pin holds it, as the pin is still reset.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         state <= FETCH;
         cfg_byte <= 8'h00;
      end else begin
         case (state)
            FETCH: begin
               if (reset_pin_n_in) begin
                  state <= CAPTURE; // R01 R06
               end
            end
            CAPTURE: begin
               cfg_byte <= flash_data_in; // R18
               if (decode_clk(flash_data_in) == cfg_loader_pkg::CLK_CRYSTAL) begin
                  state <= SETTLE; // R04
               end else begin
                  state <= RUN; // R04
               end
            end
            SETTLE: begin
               if (settle_done) begin
                  state <= RUN;
               end
            end
            default: begin
               state <= RUN;
            end
         endcase
      end
   end

   assign flash_rd_out = (state == FETCH); // R01
   assign flash_addr_out = `CFG_FLASH_ADDR;
   assign settle_start = (state == CAPTURE) &&
      (decode_clk(flash_data_in) == cfg_loader_pkg::CLK_CRYSTAL);
   assign config_valid_out = (state == RUN);
   assign loaded_pulse = (state != RUN) && (state != FETCH) && (
      (state == CAPTURE && decode_clk(flash_data_in) != cfg_loader_pkg::CLK_CRYSTAL) ||
      (state == SETTLE && settle_done));

   // Settling wait of 2^n main clock periods.
   settle_timer #(
      .CNT_W(SETTLE_W)
   ) u_settle (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .start_in(settle_start),
      .sel_in(cfg_byte[`CFG_SETTLE_HI_BIT:`CFG_SETTLE_LO_BIT]), // R03
      .done_out(settle_done)
   );

   // Held settings decoded from the captured byte.
   always_comb begin
      settings_out.settle_sel = cfg_byte[`CFG_SETTLE_HI_BIT:`CFG_SETTLE_LO_BIT];
      settings_out.reset_pin_function_sel = cfg_byte[`CFG_RESET_PIN_BIT];
      settings_out.clk_source = decode_clk(cfg_byte); // R07
      settings_out.slow_osc_lock = cfg_byte[`CFG_SLOW_LOCK_BIT];
   end

   // ----------------------------------------------------------------------
   // Pins and reset
   // ----------------------------------------------------------------------

   // Before the byte is applied the shared pin still acts as reset.
   always_comb begin
      pin_roles_out.reset_pin_as_input = config_valid_out &&
         !cfg_byte[`CFG_RESET_PIN_BIT]; // R05
      pin_roles_out.osc_pin_a_port = config_valid_out &&
         (settings_out.clk_source == cfg_loader_pkg::CLK_INTERNAL); // R08
      pin_roles_out.osc_pin_b_port = config_valid_out &&
         (settings_out.clk_source != cfg_loader_pkg::CLK_CRYSTAL); // R08
   end

   // Internal reset from the pin, the detector in reset mode, or loading.
   assign core_reset_out = !config_valid_out ||
      (!reset_pin_n_in && !pin_roles_out.reset_pin_as_input) || // R05 R06
      (uv_enable && uv_reset_mode && supply_low_in); // R13

   // ----------------------------------------------------------------------
   // Slow oscillator and clock gating
   // ----------------------------------------------------------------------

   assign slow_osc_run_out = settings_out.slow_osc_lock || !slow_osc_halt_req; // R09
   assign wdt_force_slow_out = settings_out.slow_osc_lock; // R10
   assign wdt_clk_en_out = settings_out.slow_osc_lock ? 1'b1 : // R10
      (!halt_mode_in && !stop_mode_in && wdt_sel_slow_in && slow_osc_run_out); // R11
   assign timer_h1_clk_en_out = slow_osc_run_out; // R12

   // ----------------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------------

   assign wr_uv = reg_wr_in && (reg_addr_in == `REG_UV_DETECT);
   assign wr_pend = reg_wr_in && (reg_addr_in == `REG_IRQ_FLAGS0);
   assign uv_enable = undervolt_detect_reg[`UV_ENABLE_BIT];
   assign uv_reset_mode = undervolt_detect_reg[`UV_MODE_BIT];
   assign undervolt_flag = uv_enable && supply_low_in; // R17

   // Writable control: detector control, the slow oscillator halt bit and the event mask.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         undervolt_detect_reg <= `UV_DETECT_RST;
         slow_osc_halt_req <= 1'b0;
         evt_mask <= `EVT_MASK_RST;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `REG_UV_DETECT) begin
            undervolt_detect_reg <= reg_wdata_in & 8'h82;
         end else if (reg_addr_in == `REG_SLOW_OSC_MODE) begin
            slow_osc_halt_req <= reg_wdata_in[`SLOW_HALT_BIT];
         end else if (reg_addr_in == `REG_EVT_MASK) begin
            evt_mask <= reg_wdata_in[1:0];
         end
      end
   end

   // Pending flag sets on a rising detect in interrupt mode; a new event wins.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         uv_flag_prev <= 1'b0;
         irq_request_flags_0 <= 1'b0;
      end else begin
         uv_flag_prev <= undervolt_flag;
         if (undervolt_flag && !uv_flag_prev && !uv_reset_mode) begin
            irq_request_flags_0 <= 1'b1;
         end else if (wr_pend && !reg_wdata_in[`UV_PEND_BIT]) begin
            irq_request_flags_0 <= 1'b0; // R14
         end
      end
   end

   assign evt_in = {undervolt_flag && !uv_flag_prev, loaded_pulse};
   assign evt_clear = (reg_wr_in && reg_addr_in == `REG_EVT_STATUS) ?
      reg_wdata_in[1:0] : 2'b00;

   event_irq #(
      .N(2)
   ) u_evt (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .event_in(evt_in),
      .clear_in(evt_clear),
      .mask_in(evt_mask),
      .status_out(evt_status),
      .irq_out(irq_out)
   );

   // Read data one cycle after the strobe; unmapped addresses read zero.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         if (reg_addr_in == `REG_CFG_BYTE) begin
            reg_rdata_out <= cfg_byte; // R18
         end else if (reg_addr_in == `REG_UV_DETECT) begin
            reg_rdata_out <= {undervolt_detect_reg[7:1], undervolt_flag}; // R15
         end else if (reg_addr_in == `REG_IRQ_FLAGS0) begin
            reg_rdata_out <= {6'h00, irq_request_flags_0, 1'b0}; // R14
         end else if (reg_addr_in == `REG_SLOW_OSC_MODE) begin
            reg_rdata_out <= {7'h00, slow_osc_halt_req};
         end else if (reg_addr_in == `REG_EVT_STATUS) begin
            reg_rdata_out <= {6'h00, evt_status};
         end else if (reg_addr_in == `REG_EVT_MASK) begin
            reg_rdata_out <= {6'h00, evt_mask};
         end else begin
            reg_rdata_out <= 8'h00;
         end
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------

   sequence fetch_then_capture_s;
      flash_rd_out ##1 (state == CAPTURE);
   endsequence

   fetch_order_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R01
      ($rose(rstn_in) && reset_pin_n_in) |-> fetch_then_capture_s)
      else $error("fetch did not follow reset release");
   no_wait_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R04
      (state == CAPTURE && decode_clk(flash_data_in) != cfg_loader_pkg::CLK_CRYSTAL)
      |=> config_valid_out)
      else $error("settle wait inserted for non crystal source");
   reset_hold_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R06
      (state == FETCH && !reset_pin_n_in) |=> (state == FETCH && core_reset_out))
      else $error("reset released before configuration applied");
   slow_lock_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R09
      settings_out.slow_osc_lock |-> slow_osc_run_out)
      else $error("locked slow oscillator stopped");
   wdt_gate_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R11
      (!settings_out.slow_osc_lock && (halt_mode_in || stop_mode_in)) |-> !wdt_clk_en_out)
      else $error("watchdog clock running in halt or stop");
   cfg_hold_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R18
      (config_valid_out && $past(config_valid_out)) |-> $stable(cfg_byte))
      else $error("held configuration changed");
   pend_clear_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R14
      (wr_pend && !reg_wdata_in[`UV_PEND_BIT] && !(undervolt_flag && !uv_flag_prev))
      |=> !irq_request_flags_0)
      else $error("pending flag not cleared by zero write");
   uv_reset_a: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // R13
      (uv_enable && uv_reset_mode && supply_low_in) |-> core_reset_out)
      else $error("detector reset not asserted");

endmodule

// [verilog/settle_timer.sv]
/*
 * Oscillator settling counter: counts 2^exp main clock periods once started.
 * Assumes start is a one-cycle pulse and exp selects one of four waits.
 */
`timescale 1ns/1ps
`include "cfg_loader_defs.svh"

module settle_timer #(
   parameter int CNT_W = 18
) (
   // Clock and reset.
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Control.
   input wire logic start_in,
   input wire logic [1:0] sel_in,
   // Status.
   output logic done_out
);

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] limit;
   logic running;

   // Wait length in main clock periods for the given selector.
   function automatic logic [CNT_W-1:0] wait_len(input logic [1:0] sel);
      logic [CNT_W-1:0] one;
      one = {{(CNT_W-1){1'b0}}, 1'b1};
      case (sel)
         2'h0: wait_len = one << `SETTLE_EXP_0;
         2'h1: wait_len = one << `SETTLE_EXP_1;
         2'h2: wait_len = one << `SETTLE_EXP_2;
         default: wait_len = one << `SETTLE_EXP_3;
      endcase
   endfunction

   assign limit = wait_len(sel_in);

   // Counter runs from the start pulse until the limit is reached.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         count <= '0;
         running <= 1'b0;
         done_out <= 1'b0;
      end else if (start_in) begin
         count <= {{(CNT_W-1){1'b0}}, 1'b1};
         running <= 1'b1;
         done_out <= 1'b0;
      end else if (running) begin
         if (count == limit) begin
            running <= 1'b0;
            done_out <= 1'b1;
         end else begin
            count <= count + 1'b1;
         end
      end
   end

endmodule
